// file: power_mode_defs.svh
// offsets, field positions, reset values and counts for the power mode block
`ifndef POWER_MODE_DEFS_SVH
`define POWER_MODE_DEFS_SVH

`define NUM_POWER_MODES      5
`define ADDR_FLASH_TIMING    8'hB6
`define ADDR_POWER_CONTROL   8'h87
`define ADDR_PMU_CONFIG      8'hB5
`define ADDR_WAKE_FLAGS      8'hB4

`define FLASH_BYPASS_BIT     6
`define FLASH_TIMING_RESET   8'h00
`define FLASH_TIMING_MASK    8'h40

`define PWR_IDLE_BIT         0
`define PWR_STOP_BIT         1
`define POWER_CONTROL_RESET  8'h00

`define PMU_SUSPEND_BIT      0
`define PMU_SLEEP_BIT        1
`define PMU_TWO_CELL_BIT     2
`define PMU_WAKE_EN_LSB      4
`define PMU_CONFIG_RESET     8'h00
`define PMU_CONFIG_MASK      8'hF7

`define WAKE_RTC             0
`define WAKE_PORT_MATCH      1
`define WAKE_COMP0           2
`define WAKE_RESET_PIN       3

`define RESET_VECTOR         16'h0000

`endif

// file: power_mode_pkg.sv
// types shared by the power mode block
`default_nettype none
package power_mode_pkg;

	typedef enum logic [6:0] {
		PM_NORMAL  = 7'b0000001,
		PM_IDLE    = 7'b0000010,
		PM_STOP    = 7'b0000100,
		PM_SUSPEND = 7'b0001000,
		PM_SLEEP   = 7'b0010000,
		PM_SPARE0  = 7'b0100000,
		PM_SPARE1  = 7'b1000000
	} power_state_e;

	typedef logic [3:0] wake_vec_t;

endpackage
`default_nettype wire

// file: pmu_wake_detect.sv
// wake source qualification for suspend and sleep
`timescale 1ns/100ps
`default_nettype none
`include "power_mode_defs.svh"

module pmu_wake_detect (
	input  wire logic                    core_clk,
	input  wire logic                    arst_n,
	input  wire logic                    armed,
	input  wire logic                    sleepMode,
	input  wire logic                    twoCell,
	input  wire logic                    rtcEvent,
	input  wire logic                    portMatch,
	input  wire logic                    comp0Rise,
	input  wire logic                    rstPinFall,
	input  wire logic [2:0]              wakeEn,
	output logic                         wakeHit,
	output power_mode_pkg::wake_vec_t    wakeSrc
);

	power_mode_pkg::wake_vec_t hitNow;

	always_comb begin
		hitNow = '0;
		hitNow[`WAKE_RTC] = rtcEvent & wakeEn[`WAKE_RTC];
		hitNow[`WAKE_PORT_MATCH] = portMatch & wakeEn[`WAKE_PORT_MATCH];
		// comparator has no supply in sleep unless running from two cells
		hitNow[`WAKE_COMP0] = comp0Rise & wakeEn[`WAKE_COMP0] & (twoCell | ~sleepMode);
		// reset pin edge wakes suspend or sleep with no enable bit, even a glitch too short to reset
		hitNow[`WAKE_RESET_PIN] = rstPinFall;
		if (!armed) begin
			hitNow = '0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wakeHit <= 1'b0;
			wakeSrc <= '0;
		end else begin
			wakeHit <= |hitNow;
			wakeSrc <= hitNow;
		end
	end

endmodule
`default_nettype wire

// file: power_mode_ctrl.sv
// power mode sequencer with flash timing and power control registers
`timescale 1ns/100ps
`default_nettype none
`include "power_mode_defs.svh"

module power_mode_ctrl (
	input  wire logic                    core_clk,
	input  wire logic                    arst_n,
	input  wire logic [7:0]              sfrAddr,
	input  wire logic                    sfrWrEn,
	input  wire logic                    sfrRdEn,
	input  wire logic [7:0]              sfrWdata,
	output logic      [7:0]              sfrRdata,
	input  wire logic                    instrDone,
	input  wire logic                    intPending,
	input  wire logic                    resetEvent,
	input  wire logic                    wdtExpire,
	input  wire logic                    rtcEvent,
	input  wire logic                    portMatch,
	input  wire logic                    comp0Rise,
	input  wire logic                    rstPinFall,
	output logic                         cpuHalt,
	output logic                         resumePulse,
	output logic                         coreResetReq,
	output logic      [15:0]             resetVector,
	output logic                         preciseOscEn,
	output logic                         lowPowerOscEn,
	output logic                         sysClkEn,
	output logic                         coreSupplyEn,
	output logic                         oneShotEn,
	output power_mode_pkg::power_state_e powerMode
);

	power_mode_pkg::power_state_e state_reg;
	power_mode_pkg::power_state_e state_next;
	logic [7:0]                flashTiming_reg;
	logic [7:0]                powerControl_reg;
	logic [7:0]                pmuConfig_reg;
	power_mode_pkg::wake_vec_t wakeFlags_reg;
	logic                      anyReset;
	logic                      wakeHit;
	power_mode_pkg::wake_vec_t wakeSrc;
	logic                      idleWake;
	logic                      lpWake;
	logic                      wrFlash;
	logic                      wrPower;
	logic                      wrPmu;
	logic                      wrFlags;

	// one address compare per register, used by the write strobes
	function automatic logic hitAddr(input logic [7:0] addr, input logic [7:0] target);
		hitAddr = (addr == target);
	endfunction

	assign wrFlash = sfrWrEn & hitAddr(sfrAddr, `ADDR_FLASH_TIMING);
	assign wrPower = sfrWrEn & hitAddr(sfrAddr, `ADDR_POWER_CONTROL);
	assign wrPmu   = sfrWrEn & hitAddr(sfrAddr, `ADDR_PMU_CONFIG);
	assign wrFlags = sfrWrEn & hitAddr(sfrAddr, `ADDR_WAKE_FLAGS);

	// watchdog expiry is just another reset source here
	assign anyReset = resetEvent | wdtExpire;
	// peripherals are not gated in idle; only an enabled interrupt wakes
	assign idleWake = (state_reg == power_mode_pkg::PM_IDLE) & intPending;
	assign lpWake   = wakeHit &
		((state_reg == power_mode_pkg::PM_SUSPEND) | (state_reg == power_mode_pkg::PM_SLEEP));

	pmu_wake_detect u_wake (
		.core_clk   (core_clk),
		.arst_n     (arst_n),
		.armed      ((state_reg == power_mode_pkg::PM_SUSPEND) |
			(state_reg == power_mode_pkg::PM_SLEEP)),
		.sleepMode  (state_reg == power_mode_pkg::PM_SLEEP),
		.twoCell    (pmuConfig_reg[`PMU_TWO_CELL_BIT]),
		.rtcEvent   (rtcEvent),
		.portMatch  (portMatch),
		.comp0Rise  (comp0Rise),
		.rstPinFall (rstPinFall),
		.wakeEn     (pmuConfig_reg[`PMU_WAKE_EN_LSB +: 3]),
		.wakeHit    (wakeHit),
		.wakeSrc    (wakeSrc)
	);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			power_mode_pkg::PM_NORMAL: begin
				// entry waits for the end of the instruction that wrote the bit
				if (instrDone) begin
					if (powerControl_reg[`PWR_STOP_BIT]) begin
						state_next = power_mode_pkg::PM_STOP;
					end else if (pmuConfig_reg[`PMU_SLEEP_BIT]) begin
						state_next = power_mode_pkg::PM_SLEEP;
					end else if (pmuConfig_reg[`PMU_SUSPEND_BIT]) begin
						state_next = power_mode_pkg::PM_SUSPEND;
					end else if (powerControl_reg[`PWR_IDLE_BIT]) begin
						state_next = power_mode_pkg::PM_IDLE;
					end
				end
			end
			power_mode_pkg::PM_IDLE: begin
				if (idleWake) begin
					state_next = power_mode_pkg::PM_NORMAL;
				end
			end
			// stop has no exit except the reset path below
			power_mode_pkg::PM_STOP: state_next = power_mode_pkg::PM_STOP;
			power_mode_pkg::PM_SUSPEND, power_mode_pkg::PM_SLEEP: begin
				if (lpWake) begin
					state_next = power_mode_pkg::PM_NORMAL;
				end
			end
			default: state_next = power_mode_pkg::PM_NORMAL;
		endcase
		if (anyReset) begin
			state_next = power_mode_pkg::PM_NORMAL;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= power_mode_pkg::PM_NORMAL;
		end else begin
			state_reg <= state_next;
		end
	end

	// reserved bits are masked so they always read back as zero
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flashTiming_reg <= `FLASH_TIMING_RESET;
		end else if (anyReset) begin
			flashTiming_reg <= `FLASH_TIMING_RESET;
		end else if (wrFlash) begin
			flashTiming_reg <= sfrWdata & `FLASH_TIMING_MASK;
		end
	end

	// core is halted outside normal, so a write never meets a wake clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			powerControl_reg <= `POWER_CONTROL_RESET;
		end else if (anyReset) begin
			powerControl_reg <= `POWER_CONTROL_RESET;
		end else if (idleWake) begin
			powerControl_reg[`PWR_IDLE_BIT] <= 1'b0;
		end else if (wrPower) begin
			powerControl_reg <= sfrWdata;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pmuConfig_reg <= `PMU_CONFIG_RESET;
		end else if (anyReset) begin
			pmuConfig_reg <= `PMU_CONFIG_RESET;
		end else if (lpWake) begin
			pmuConfig_reg[`PMU_SUSPEND_BIT] <= 1'b0;
			pmuConfig_reg[`PMU_SLEEP_BIT] <= 1'b0;
		end else if (wrPmu) begin
			pmuConfig_reg <= sfrWdata & `PMU_CONFIG_MASK;
		end
	end

	// write one clears; a fresh wake in the same cycle still lands
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wakeFlags_reg <= '0;
		end else if (anyReset) begin
			wakeFlags_reg <= '0;
		end else begin
			wakeFlags_reg <= (wakeFlags_reg & ~(wrFlags ? sfrWdata[3:0] : 4'h0)) |
				(lpWake ? wakeSrc : 4'h0);
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sfrRdata <= 8'h00;
		end else if (sfrRdEn) begin
			unique case (1'b1)
				hitAddr(sfrAddr, `ADDR_FLASH_TIMING):  sfrRdata <= flashTiming_reg;
				hitAddr(sfrAddr, `ADDR_POWER_CONTROL): sfrRdata <= powerControl_reg;
				hitAddr(sfrAddr, `ADDR_PMU_CONFIG):    sfrRdata <= pmuConfig_reg;
				hitAddr(sfrAddr, `ADDR_WAKE_FLAGS):    sfrRdata <= {4'h0, wakeFlags_reg};
				default:                               sfrRdata <= 8'h00;
			endcase
		end
	end

	// pulses: resume hands control back so the core serves the interrupt
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			resumePulse  <= 1'b0;
			coreResetReq <= 1'b0;
			resetVector  <= `RESET_VECTOR;
		end else begin
			resumePulse  <= ~anyReset & (idleWake | lpWake);
			coreResetReq <= anyReset;
			resetVector  <= `RESET_VECTOR;
		end
	end

	// memory and register contents are untouched by any low-power state
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cpuHalt       <= 1'b0;
			preciseOscEn  <= 1'b1;
			lowPowerOscEn <= 1'b1;
			sysClkEn      <= 1'b1;
			coreSupplyEn  <= 1'b1;
			powerMode     <= power_mode_pkg::PM_NORMAL;
		end else begin
			cpuHalt       <= (state_next != power_mode_pkg::PM_NORMAL);
			preciseOscEn  <= (state_next == power_mode_pkg::PM_NORMAL) |
				(state_next == power_mode_pkg::PM_IDLE);
			lowPowerOscEn <= (state_next != power_mode_pkg::PM_SUSPEND) &
				(state_next != power_mode_pkg::PM_SLEEP);
			sysClkEn      <= (state_next != power_mode_pkg::PM_SUSPEND) &
				(state_next != power_mode_pkg::PM_SLEEP);
			coreSupplyEn  <= (state_next != power_mode_pkg::PM_SLEEP);
			powerMode     <= state_next;
		end
	end

	// one-shot only runs with bypass clear; needed for a real low-power idle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			oneShotEn <= 1'b1;
		end else begin
			oneShotEn <= ~flashTiming_reg[`FLASH_BYPASS_BIT];
		end
	end

endmodule
`default_nettype wire

// file: power_mode_ctrl_assertions.sv
// checker for the power mode sequencer ports
`timescale 1ns/100ps
`default_nettype none
module power_mode_ctrl_assertions (
	input wire logic core_clk, arst_n, sfrWrEn, sfrRdEn, instrDone, intPending,
	input wire logic resetEvent, wdtExpire, cpuHalt, resumePulse, coreResetReq,
	input wire logic preciseOscEn, lowPowerOscEn, sysClkEn, coreSupplyEn, oneShotEn,
	input wire logic [7:0] sfrAddr, sfrWdata, sfrRdata,
	input wire logic [15:0] resetVector,
	input wire power_mode_pkg::power_state_e powerMode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic pmuSel;
	logic quiet;
	// suspend or sleep selection outranks idle, so entry checks skip it
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) pmuSel <= 1'b0;
		else if (resetEvent || wdtExpire) pmuSel <= 1'b0;
		else if (sfrWrEn && sfrAddr == 8'hB5) pmuSel <= |sfrWdata[1:0];
	end
	assign quiet = !sfrWrEn && !resetEvent && !wdtExpire && !intPending && !pmuSel;
	sequence armThen(logic [7:0] d);
		sfrWrEn && sfrAddr == 8'h87 && sfrWdata == d && powerMode == power_mode_pkg::PM_NORMAL
		##1 (quiet && !instrDone) ##1 (instrDone && quiet);
	endsequence
	property bypassWr;
		logic b;
		(sfrWrEn && sfrAddr == 8'hB6 && !resetEvent && !wdtExpire, b = sfrWdata[6])
		|-> ##2 oneShotEn == !b;
	endproperty
	a_idle_entry: assert property (armThen(8'h01) |=>
		powerMode == power_mode_pkg::PM_IDLE && cpuHalt) else $error("idle not entered");
	a_stop_priority: assert property (armThen(8'h03) |=>
		powerMode == power_mode_pkg::PM_STOP && !preciseOscEn) else $error("stop not entered");
	a_idle_keeps_clocks: assert property (powerMode == power_mode_pkg::PM_IDLE |->
		sysClkEn && coreSupplyEn && preciseOscEn) else $error("idle clocks off");
	a_idle_hold: assert property (powerMode == power_mode_pkg::PM_IDLE && !intPending
		&& !resetEvent && !wdtExpire |=> powerMode == power_mode_pkg::PM_IDLE)
		else $error("idle left without cause");
	a_idle_int_wake: assert property (powerMode == power_mode_pkg::PM_IDLE && intPending
		&& !resetEvent && !wdtExpire |=> powerMode == power_mode_pkg::PM_NORMAL && resumePulse)
		else $error("interrupt did not wake idle");
	a_resume_once: assert property (resumePulse |-> !cpuHalt ##1 !resumePulse)
		else $error("resume pulse wrong");
	a_reset_restart: assert property (resetEvent |=> coreResetReq && !cpuHalt
		&& resetVector == 16'h0000) else $error("reset did not restart");
	a_wdt_reset: assert property (wdtExpire |=> coreResetReq
		&& powerMode == power_mode_pkg::PM_NORMAL) else $error("watchdog did not reset");
	a_bypass_write: assert property (bypassWr)
		else $error("one-shot enable wrong");
	a_reserved_zero: assert property (sfrRdEn && sfrAddr == 8'hB6 |=>
		sfrRdata[7] == 1'b0 && sfrRdata[5:0] == 6'h00) else $error("reserved bits set");
	a_stop_hold: assert property (powerMode == power_mode_pkg::PM_STOP && !resetEvent
		&& !wdtExpire |=> powerMode == power_mode_pkg::PM_STOP && !preciseOscEn)
		else $error("stop left without reset");
	a_suspend_gates: assert property (powerMode == power_mode_pkg::PM_SUSPEND |->
		!sysClkEn && !lowPowerOscEn && !preciseOscEn) else $error("suspend clocks on");
	a_sleep_supply: assert property (powerMode == power_mode_pkg::PM_SLEEP |->
		!coreSupplyEn && !sysClkEn && cpuHalt) else $error("sleep supply on");
endmodule
bind power_mode_ctrl power_mode_ctrl_assertions u_power_mode_ctrl_assertions (.core_clk,
	.arst_n, .sfrWrEn, .sfrRdEn, .instrDone, .intPending, .resetEvent, .wdtExpire, .cpuHalt,
	.resumePulse, .coreResetReq, .preciseOscEn, .lowPowerOscEn, .sysClkEn, .coreSupplyEn,
	.oneShotEn, .sfrAddr, .sfrWdata, .sfrRdata, .resetVector, .powerMode);
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the power mode sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam logic [6:0] DOG = 7'h40, RST = 7'h20, INT = 7'h10, RTC = 7'h08;
	localparam logic [6:0] PORT = 7'h04, CMP = 7'h02, PIN = 7'h01;
	logic core_clk, arst_n, sfrWrEn, sfrRdEn, instrDone, intPending, resetEvent, wdtExpire;
	logic rtcEvent, portMatch, comp0Rise, rstPinFall, cpuHalt, resumePulse, coreResetReq;
	logic preciseOscEn, lowPowerOscEn, sysClkEn, coreSupplyEn, oneShotEn;
	logic [7:0] sfrAddr, sfrWdata, sfrRdata;
	logic [15:0] resetVector;
	power_mode_pkg::power_state_e powerMode;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	power_mode_ctrl u_power_mode_ctrl (.core_clk, .arst_n, .sfrAddr, .sfrWrEn, .sfrRdEn,
		.sfrWdata, .sfrRdata, .instrDone, .intPending, .resetEvent, .wdtExpire, .rtcEvent,
		.portMatch, .comp0Rise, .rstPinFall, .cpuHalt, .resumePulse, .coreResetReq,
		.resetVector, .preciseOscEn, .lowPowerOscEn, .sysClkEn, .coreSupplyEn, .oneShotEn,
		.powerMode);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task report_and_stop;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// a hang costs one mismatch and ends the run
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			report_and_stop();
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		sfrWrEn <= 1'b1;
		sfrAddr <= a;
		sfrWdata <= d;
		@(posedge core_clk);
		sfrWrEn <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		sfrRdEn <= 1'b1;
		sfrAddr <= a;
		@(posedge core_clk);
		sfrRdEn <= 1'b0;
		#1 chk(16'(sfrRdata), 16'(exp));
	endtask
	task go;
		@(posedge core_clk);
		instrDone <= 1'b1;
		@(posedge core_clk);
		instrDone <= 1'b0;
		#1;
	endtask
	// suspend and sleep wakes need one extra cycle to qualify the event
	task fire(input logic [6:0] v, input int n);
		@(posedge core_clk);
		{wdtExpire, resetEvent, intPending, rtcEvent, portMatch, comp0Rise, rstPinFall} <= v;
		@(posedge core_clk);
		{wdtExpire, resetEvent, intPending, rtcEvent, portMatch, comp0Rise, rstPinFall} <= 7'h00;
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task mode(input power_mode_pkg::power_state_e m);
		chk(16'(powerMode), 16'(m));
	endtask
	initial begin
		{arst_n, sfrWrEn, sfrRdEn, instrDone, sfrAddr, sfrWdata} = '0;
		{wdtExpire, resetEvent, intPending, rtcEvent, portMatch, comp0Rise, rstPinFall} = '0;
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		#1 mode(power_mode_pkg::PM_NORMAL);
		chk(16'(oneShotEn), 16'h0001);
		rd(8'hB6, 8'h00);
		rd(8'h87, 8'h00);
		rd(8'h11, 8'h00);
		wr(8'hB6, 8'hFF);
		rd(8'hB6, 8'h40);
		chk(16'(oneShotEn), 16'h0000);
		wr(8'hB6, 8'h00);
		rd(8'hB6, 8'h00);
		chk(16'(oneShotEn), 16'h0001);
		wr(8'hB5, 8'h70);
		wr(8'h87, 8'h01);
		go();
		mode(power_mode_pkg::PM_IDLE);
		chk(16'(cpuHalt), 16'h0001);
		chk(16'(sysClkEn), 16'h0001);
		fire(RTC | PORT | CMP | PIN, 0);
		mode(power_mode_pkg::PM_IDLE);
		// watchdog kept silent, so idle must simply persist
		repeat (20) @(posedge core_clk);
		#1 mode(power_mode_pkg::PM_IDLE);
		fire(INT, 0);
		chk(16'(resumePulse), 16'h0001);
		mode(power_mode_pkg::PM_NORMAL);
		rd(8'h87, 8'h00);
		rd(8'hB5, 8'h70);
		wr(8'h87, 8'h01);
		go();
		fire(RST, 0);
		chk(16'(coreResetReq), 16'h0001);
		chk(resetVector, 16'h0000);
		mode(power_mode_pkg::PM_NORMAL);
		rd(8'hB6, 8'h00);
		rd(8'hB5, 8'h00);
		wr(8'h87, 8'h01);
		go();
		fire(DOG, 0);
		chk(16'(coreResetReq), 16'h0001);
		chk(16'(cpuHalt), 16'h0000);
		wr(8'h87, 8'h03);
		go();
		mode(power_mode_pkg::PM_STOP);
		chk(16'(preciseOscEn), 16'h0000);
		fire(INT | RTC | PIN, 1);
		mode(power_mode_pkg::PM_STOP);
		fire(RST, 0);
		mode(power_mode_pkg::PM_NORMAL);
		wr(8'hB5, 8'h11);
		go();
		mode(power_mode_pkg::PM_SUSPEND);
		chk(16'(sysClkEn), 16'h0000);
		chk(16'(lowPowerOscEn), 16'h0000);
		fire(PORT, 1);
		mode(power_mode_pkg::PM_SUSPEND);
		fire(RTC, 1);
		chk(16'(resumePulse), 16'h0001);
		mode(power_mode_pkg::PM_NORMAL);
		rd(8'hB4, 8'h01);
		wr(8'hB5, 8'h42);
		go();
		mode(power_mode_pkg::PM_SLEEP);
		chk(16'(coreSupplyEn), 16'h0000);
		fire(CMP, 1);
		mode(power_mode_pkg::PM_SLEEP);
		fire(PIN, 1);
		mode(power_mode_pkg::PM_NORMAL);
		rd(8'hB4, 8'h09);
		wr(8'hB5, 8'h46);
		go();
		fire(CMP, 1);
		mode(power_mode_pkg::PM_NORMAL);
		rd(8'hB4, 8'h0D);
		wr(8'hB6, 8'h40);
		rd(8'hB6, 8'h40);
		chk(16'(oneShotEn), 16'h0000);
		report_and_stop();
	end
endmodule
`default_nettype wire
